// *** core/bfield_length_select.sv ***
// Looks up B-field bit counts for a slot format and modulation pair.
// Pure combinational; the caller holds its inputs stable through a burst.
module bfield_length_select (
   // Burst configuration
   input wire mapper_pkg::cfg_s cfg_i,
   // Counts
   output logic [mapper_pkg::COUNT_W-1:0] total_bits_o,
   output logic [mapper_pkg::COUNT_W-1:0] enc_bits_o
);

   logic [mapper_pkg::COUNT_W-1:0] half_count;

   // Half slot count grows with j; product is cut to the count width on purpose
   assign half_count = mapper_pkg::HALF_BASE[cfg_i.mod_pair]
      + mapper_pkg::COUNT_W'(mapper_pkg::COUNT_W'(cfg_i.j) * mapper_pkg::HALF_MULT[cfg_i.mod_pair]);

   // count tables
   // Total data bits of the B-field, and the span that takes key stream bits
   always_comb begin
      total_bits_o = '0;
      case (cfg_i.slot)
         mapper_pkg::SLOT_HALF: total_bits_o = half_count;
         mapper_pkg::SLOT_FULL: total_bits_o = mapper_pkg::UNPROT_FULL[cfg_i.mod_pair];
         mapper_pkg::SLOT_DOUBLE: total_bits_o = mapper_pkg::UNPROT_DOUBLE[cfg_i.mod_pair];
         default: total_bits_o = '0;
      endcase
      enc_bits_o = total_bits_o;
      if (cfg_i.fmt == mapper_pkg::FMT_SINGLE) begin
         case (cfg_i.slot)
            mapper_pkg::SLOT_FULL: enc_bits_o = mapper_pkg::SINGLE_FULL[cfg_i.mod_pair];
            mapper_pkg::SLOT_DOUBLE: enc_bits_o = mapper_pkg::SINGLE_DOUBLE[cfg_i.mod_pair];
            default: enc_bits_o = '0;
         endcase
      end
   end

endmodule // bfield_length_select

// *** core/bit_fifo.sv ***
// Small synchronous FIFO in flip-flops, valid/ready on both sides.
// Assumes one clock; ready and valid flags are registered from the next count.
module bit_fifo #(
   parameter int WIDTH = 3,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Fill side
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   // Drain side
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);

   localparam int PTR_W = $clog2(DEPTH);
   localparam int CNT_W = $clog2(DEPTH + 1);
   localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
   localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] next_count;
   logic push;
   logic pop;

   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_data_o = mem[rd_ptr];

   // Occupancy after this edge
   always_comb begin
      next_count = count;
      if (push && !pop) begin
         next_count = count + 1'b1;
      end else if (pop && !push) begin
         next_count = count - 1'b1;
      end
   end

   // Storage write
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   // Pointers wrap at any depth, not only powers of two
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
         end
      end
   end

   // Flags come from the next count so they are exact yet registered
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count <= '0;
         in_ready_o <= 1'b0;
         out_valid_o <= 1'b0;
      end else begin
         count <= next_count;
         in_ready_o <= (next_count != FULL_CNT);
         out_valid_o <= (next_count != '0);
      end
   end

endmodule // bit_fifo

// *** core/keystream_bfield_xor_mapper.sv ***
// Maps key stream segment bits onto A-field tail and B-field bits of a burst.
// Assumes key stream and burst bits arrive in order, one bit per handshake.
module keystream_bfield_xor_mapper #(
   parameter int FIFO_DEPTH = 16
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Key stream segment bits
   input wire logic ks_valid_i,
   input wire logic ks_bit_i,
   output logic ks_ready_o,
   // Burst bits in: A bits 8..47, then B-field bits
   input wire logic din_valid_i,
   input wire logic din_bit_i,
   output logic din_ready_o,
   // Mapped burst bits out
   output logic dout_valid_o,
   output logic dout_bit_o,
   output logic dout_applied_o,
   output logic dout_last_o,
   input wire logic dout_ready_i
);

   localparam int ITEM_W = $bits(mapper_pkg::map_item_s);
   localparam logic [mapper_pkg::COUNT_W-1:0] ONE_CNT = 12'h001;

   mapper_pkg::cfg_s cfg_reg;
   mapper_pkg::cfg_s active;
   mapper_pkg::state_e state;
   logic [mapper_pkg::COUNT_W-1:0] key_idx;
   logic [mapper_pkg::SUB_W-1:0] sub_pos;
   logic [mapper_pkg::COUNT_W-1:0] total_bits;
   logic [mapper_pkg::COUNT_W-1:0] enc_bits;
   logic [mapper_pkg::COUNT_W-1:0] b_idx;
   logic done;
   logic cfg_error;
   logic fifo_in_ready;
   logic take;
   logic in_a;
   logic apply;
   logic last;
   logic cfg_ok;
   logic bus_req;
   logic wr_ctrl;
   logic wr_cfg;
   logic wr_status;
   logic start;
   logic abort;
   mapper_pkg::map_item_s item;
   mapper_pkg::map_item_s head;

   // Bus request decode; one access per request, ack follows one cycle later
   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_ctrl = bus_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == mapper_pkg::REG_CTRL);
   assign wr_cfg = bus_req && wb_we_i && (wb_adr_i == mapper_pkg::REG_CFG);
   assign wr_status = bus_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == mapper_pkg::REG_STATUS);
   assign start = wr_ctrl && wb_dat_i[mapper_pkg::CTRL_START];
   assign abort = wr_ctrl && wb_dat_i[mapper_pkg::CTRL_ABORT];

   // slot check: single protected layout has no half slot form
   assign cfg_ok = (cfg_reg.slot != mapper_pkg::SLOT_BAD) && (cfg_reg.fmt != mapper_pkg::FMT_BAD)
      && !((cfg_reg.fmt == mapper_pkg::FMT_SINGLE) && (cfg_reg.slot == mapper_pkg::SLOT_HALF));

   // count lookup from the configuration latched at start
   bfield_length_select u_len (
      .cfg_i(active),
      .total_bits_o(total_bits),
      .enc_bits_o(enc_bits)
   );

   // A bit pairs with both inputs present and room downstream
   assign take = (state == mapper_pkg::ST_RUN) && ks_valid_i && din_valid_i && fifo_in_ready;
   // Each side is offered ready only when the other has a bit, so pairs never slip
   assign ks_ready_o = (state == mapper_pkg::ST_RUN) && fifo_in_ready && din_valid_i;
   assign din_ready_o = (state == mapper_pkg::ST_RUN) && fifo_in_ready && ks_valid_i;

   assign in_a = key_idx < mapper_pkg::A_KEY_BITS;
   assign b_idx = key_idx - mapper_pkg::A_KEY_BITS;
   assign last = key_idx == (mapper_pkg::A_KEY_BITS + total_bits - ONE_CNT);

   // Decide whether the current key bit is applied or discarded
   always_comb begin
      apply = 1'b0;
      if (in_a) begin
         apply = active.a_ctrl;
      end else if (b_idx < enc_bits) begin
         case (active.fmt)
            mapper_pkg::FMT_UNPROT: apply = 1'b1;
            mapper_pkg::FMT_SINGLE: apply = 1'b1;
            mapper_pkg::FMT_MULTI: apply = sub_pos < mapper_pkg::SUB_DATA_BITS;
            default: apply = 1'b0;
         endcase
      end
   end

   // XOR is its own inverse, so one mapping serves encrypt and decrypt
   always_comb begin
      item.bit_val = din_bit_i ^ (apply & ks_bit_i);
      item.applied = apply;
      item.last = last;
   end

   // Configuration register, byte lanes honoured
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_reg <= '0;
      end else if (wr_cfg) begin
         if (wb_sel_i[0]) begin
            cfg_reg.slot <= mapper_pkg::slot_e'(wb_dat_i[mapper_pkg::CFG_SLOT_LSB +: 2]);
            cfg_reg.mod_pair <= wb_dat_i[mapper_pkg::CFG_MOD_LSB +: 2];
            cfg_reg.fmt <= mapper_pkg::fmt_e'(wb_dat_i[mapper_pkg::CFG_FMT_LSB +: 2]);
            cfg_reg.a_ctrl <= wb_dat_i[mapper_pkg::CFG_ACTRL];
         end
         if (wb_sel_i[1]) begin
            cfg_reg.j <= wb_dat_i[mapper_pkg::CFG_J_LSB +: mapper_pkg::J_W];
         end
      end
   end

   // Burst sequencing: start latches the configuration, last bit or abort ends it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= mapper_pkg::ST_IDLE;
         active <= '0;
      end else begin
         case (state)
            mapper_pkg::ST_IDLE: begin
               if (start && cfg_ok) begin
                  state <= mapper_pkg::ST_RUN;
                  active <= cfg_reg;
               end
            end
            mapper_pkg::ST_RUN: begin
               // key bits past the last mapped bit are never taken
               if (abort || (take && last)) begin
                  state <= mapper_pkg::ST_IDLE;
               end
            end
            default: state <= mapper_pkg::ST_IDLE;
         endcase
      end
   end

   // Bit position counters; subfield position cycles through data and check
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         key_idx <= '0;
         sub_pos <= '0;
      end else if ((state == mapper_pkg::ST_IDLE) && start && cfg_ok) begin
         key_idx <= '0;
         sub_pos <= '0;
      end else if (take) begin
         key_idx <= key_idx + ONE_CNT;
         if (!in_a) begin
            sub_pos <= (sub_pos == mapper_pkg::SUB_PERIOD - 1'b1) ? '0 : sub_pos + 1'b1;
         end
      end
   end

   // Sticky flags; a set in the clearing cycle wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         done <= 1'b0;
         cfg_error <= 1'b0;
      end else begin
         if (take && last) begin
            done <= 1'b1;
         end else if (wr_status && wb_dat_i[mapper_pkg::STAT_DONE]) begin
            done <= 1'b0;
         end
         if (start && !cfg_ok) begin
            cfg_error <= 1'b1;
         end else if (wr_status && wb_dat_i[mapper_pkg::STAT_ERR]) begin
            cfg_error <= 1'b0;
         end
      end
   end

   // Read data and ack; unmapped addresses ack with zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= '0;
         if (bus_req && !wb_we_i) begin
            case (wb_adr_i)
               mapper_pkg::REG_CFG: wb_dat_o <= 32'(cfg_reg.slot)
                  | (32'(cfg_reg.mod_pair) << mapper_pkg::CFG_MOD_LSB)
                  | (32'(cfg_reg.fmt) << mapper_pkg::CFG_FMT_LSB)
                  | (32'(cfg_reg.a_ctrl) << mapper_pkg::CFG_ACTRL)
                  | (32'(cfg_reg.j) << mapper_pkg::CFG_J_LSB);
               mapper_pkg::REG_STATUS: wb_dat_o <= 32'(state == mapper_pkg::ST_RUN)
                  | (32'(done) << mapper_pkg::STAT_DONE)
                  | (32'(cfg_error) << mapper_pkg::STAT_ERR)
                  | (32'(key_idx) << mapper_pkg::STAT_CNT_LSB);
               default: wb_dat_o <= '0;
            endcase
         end
      end
   end

   // Output buffer; a stalled datapath stalls both input streams
   bit_fifo #(
      .WIDTH(ITEM_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_valid_i(take),
      .in_data_i(item),
      .in_ready_o(fifo_in_ready),
      .out_valid_o(dout_valid_o),
      .out_data_o(head),
      .out_ready_i(dout_ready_i)
   );

   assign dout_bit_o = head.bit_val;
   assign dout_applied_o = head.applied;
   assign dout_last_o = head.last;

   // Checks on the mapping
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_tail_cover: assert property (take && in_a && active.a_ctrl |-> item.bit_val == (din_bit_i ^ ks_bit_i))
      else $error("Control tail bit not covered by key stream");
   a_tail_discard: assert property (take && in_a && !active.a_ctrl |-> item.bit_val == din_bit_i)
      else $error("Key stream applied to non-control tail");
   a_unprot_span: assert property (take && active.fmt == mapper_pkg::FMT_UNPROT && !in_a |-> item.applied == (b_idx < total_bits))
      else $error("Unprotected bit mapping wrong");
   a_unprot_full: assert property (state == mapper_pkg::ST_RUN && active.slot == mapper_pkg::SLOT_FULL && active.mod_pair == 2'h0 |-> total_bits == 12'h280)
      else $error("Full slot unprotected count not 640");
   a_double_88: assert property (state == mapper_pkg::ST_RUN && active.slot == mapper_pkg::SLOT_DOUBLE && active.mod_pair == 2'h3 && active.fmt == mapper_pkg::FMT_UNPROT |-> enc_bits == 12'h9e0)
      else $error("Double slot 8/8 count not 2528");
   a_extra_bits: assert property (state == mapper_pkg::ST_RUN && active.slot == mapper_pkg::SLOT_FULL |-> total_bits - mapper_pkg::UNPROT_FULL[active.mod_pair & 2'h1] == mapper_pkg::EXTRA_BITS[active.mod_pair])
      else $error("Extra B-field bits do not match modulation");
   a_single_full: assert property (state == mapper_pkg::ST_RUN && active.fmt == mapper_pkg::FMT_SINGLE && active.slot == mapper_pkg::SLOT_FULL && active.mod_pair == 2'h2 |-> enc_bits == 12'h2a0)
      else $error("Full slot 4/4 single count not 672");
   a_single_double: assert property (state == mapper_pkg::ST_RUN && active.fmt == mapper_pkg::FMT_SINGLE && active.slot == mapper_pkg::SLOT_DOUBLE && active.mod_pair == 2'h3 |-> enc_bits == 12'h9c0)
      else $error("Double slot 8/8 single count not 2496");
   a_single_clear: assert property (take && active.fmt == mapper_pkg::FMT_SINGLE && !in_a && b_idx >= enc_bits |-> !item.applied && item.bit_val == din_bit_i)
      else $error("Single protected check or X bits encrypted");
   a_multi_first: assert property (take && active.fmt == mapper_pkg::FMT_MULTI && key_idx >= 12'h028 && key_idx <= 12'h067 |-> item.applied)
      else $error("First subfield data not encrypted");
   a_multi_check: assert property (take && active.fmt == mapper_pkg::FMT_MULTI && key_idx >= 12'h068 && key_idx <= 12'h077 |-> !item.applied)
      else $error("Subfield check bits encrypted");
   a_no_half_single: assert property (state == mapper_pkg::ST_RUN |-> !(active.fmt == mapper_pkg::FMT_SINGLE && active.slot == mapper_pkg::SLOT_HALF))
      else $error("Single protected run in half slot");
   a_end_burst: assert property (take && last |=> state == mapper_pkg::ST_IDLE && done ##1 !take)
      else $error("Key bits taken after last mapped bit");

   c_full_unprot: cover property (take && last && active.fmt == mapper_pkg::FMT_UNPROT);
   c_single_done: cover property (take && last && active.fmt == mapper_pkg::FMT_SINGLE);
   c_multi_check: cover property (take && active.fmt == mapper_pkg::FMT_MULTI && !apply && !in_a);
   c_stall: cover property (state == mapper_pkg::ST_RUN && !fifo_in_ready);

endmodule // keystream_bfield_xor_mapper

// *** shared/mapper_pkg.sv ***
// Package for the key stream to burst bit mapper.
// Holds register map, field layout, bit counts per slot format and shared types.
// Assumes the key stream generator and burst datapath deliver bits in burst order.
package mapper_pkg;

   // Register byte offsets on the Wishbone slave
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_CFG = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;

   // Control register fields
   localparam int CTRL_START = 0;
   localparam int CTRL_ABORT = 1;

   // Configuration register fields
   localparam int CFG_SLOT_LSB = 0;
   localparam int CFG_MOD_LSB = 2;
   localparam int CFG_FMT_LSB = 4;
   localparam int CFG_ACTRL = 6;
   localparam int CFG_J_LSB = 8;

   // Status register fields
   localparam int STAT_BUSY = 0;
   localparam int STAT_DONE = 1;
   localparam int STAT_ERR = 2;
   localparam int STAT_CNT_LSB = 16;

   // Widths
   localparam int COUNT_W = 12;
   localparam int J_W = 6;
   localparam int SUB_W = 7;

   // Key stream layout of a segment
   localparam logic [COUNT_W-1:0] A_KEY_BITS = 12'h028;   // 40 bits for the A-field tail
   localparam logic [SUB_W-1:0] SUB_DATA_BITS = 7'h40;    // 64 data bits per subfield
   localparam logic [SUB_W-1:0] SUB_PERIOD = 7'h50;       // 64 data plus 16 check bits

   // Modulation pairs, index order: 2/4, 2/8, 4/4, 8/8 (A-field / B-field)
   // Unprotected half slot base counts: 160, 240, 224, 368
   localparam logic [3:0][COUNT_W-1:0] HALF_BASE = {12'h170, 12'h0e0, 12'h0f0, 12'h0a0};
   // Per-j multiplier of half slot counts: 2, 3, 2, 3
   localparam logic [3:0][COUNT_W-1:0] HALF_MULT = {12'h003, 12'h002, 12'h003, 12'h002};
   // Unprotected full slot counts: 640, 960, 704, 1088
   localparam logic [3:0][COUNT_W-1:0] UNPROT_FULL = {12'h440, 12'h2c0, 12'h3c0, 12'h280};
   // Unprotected double slot counts: 1600, 2400, 1664, 2528
   localparam logic [3:0][COUNT_W-1:0] UNPROT_DOUBLE = {12'h9e0, 12'h680, 12'h960, 12'h640};
   // Single subfield protected full slot counts: 608, 928, 672, 1056
   localparam logic [3:0][COUNT_W-1:0] SINGLE_FULL = {12'h420, 12'h2a0, 12'h3a0, 12'h260};
   // Single subfield protected double slot counts: 1568, 2368, 1632, 2496
   localparam logic [3:0][COUNT_W-1:0] SINGLE_DOUBLE = {12'h9c0, 12'h660, 12'h940, 12'h620};
   // Extra B-field bits f per pair: 0, 0, 64, 128
   localparam logic [3:0][COUNT_W-1:0] EXTRA_BITS = {12'h080, 12'h040, 12'h000, 12'h000};

   typedef enum logic [1:0] {SLOT_HALF, SLOT_FULL, SLOT_DOUBLE, SLOT_BAD} slot_e;
   typedef enum logic [1:0] {FMT_UNPROT, FMT_SINGLE, FMT_MULTI, FMT_BAD} fmt_e;
   typedef enum logic {ST_IDLE, ST_RUN} state_e;

   // Burst configuration as written by software
   typedef struct packed {
      logic [J_W-1:0] j;
      logic a_ctrl;
      fmt_e fmt;
      logic [1:0] mod_pair;
      slot_e slot;
   } cfg_s;

   // One mapped bit on its way to the burst datapath
   typedef struct packed {
      logic bit_val;
      logic applied;
      logic last;
   } map_item_s;

endpackage

// *** testbench/keystream_bfield_xor_mapper_tb_top.sv ***
// Bench: register tasks over classic Wishbone, burst table, bit-exact output check.
// Assumes the partner model supplies key and burst bits from known patterns.
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_fail++; \
   $display("[ERR] %0t mismatch got %0h exp %0h", $time, (got), (exp)); end end
module keystream_bfield_xor_mapper_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic wb_ack_o, ks_valid_i, ks_bit_i, ks_ready_o, din_valid_i, din_bit_i, din_ready_o;
   logic dout_valid_o, dout_bit_o, dout_applied_o, dout_last_o, dout_ready_i;
   logic restart = 1'b0, slow = 1'b0, hold = 1'b0;
   logic [15:0] cfg = 16'h0;
   int n_fail = 0, samples_checked = 0, m = 0, len = 0, enc = 0;
   // counts per modulation pair 2/4, 2/8, 4/4, 8/8 include the extra bits
   int half_b[4] = '{160, 240, 224, 368};
   int half_m[4] = '{2, 3, 2, 3};
   int full_u[4] = '{640, 960, 704, 1088};
   int dbl_u[4] = '{1600, 2400, 1664, 2528};
   int full_s[4] = '{608, 928, 672, 1056};
   int dbl_s[4] = '{1568, 2368, 1632, 2496};
   logic [15:0] runs[12] = '{16'h0540, 16'h022c, 16'h004d, 16'h0006, 16'h0011, 16'h0015,
      16'h0019, 16'h001d, 16'h0012, 16'h0016, 16'h001a, 16'h005e};

   always #4 clk_i = ~clk_i;

   keystream_bfield_xor_mapper keystream_bfield_xor_mapper_inst (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .ks_valid_i(ks_valid_i), .ks_bit_i(ks_bit_i), .ks_ready_o(ks_ready_o),
      .din_valid_i(din_valid_i), .din_bit_i(din_bit_i), .din_ready_o(din_ready_o),
      .dout_valid_o(dout_valid_o), .dout_bit_o(dout_bit_o), .dout_applied_o(dout_applied_o),
      .dout_last_o(dout_last_o), .dout_ready_i(dout_ready_i));

   keystream_partner partner_inst (.clk_i(clk_i), .rst_i(rst_i), .restart_i(restart),
      .slow_i(slow), .hold_i(hold), .take_i(ks_valid_i & ks_ready_o),
      .ks_valid_o(ks_valid_i), .ks_bit_o(ks_bit_i), .din_valid_o(din_valid_i),
      .din_bit_o(din_bit_i), .dout_ready_o(dout_ready_i));

   // Whether key bit n should land on burst bit n under the current setup
   function automatic logic app_exp(int n);
      int i;
      i = n - 40;
      if (n < 40) return cfg[6];
      if (cfg[5:4] == 2'h0) return 1'b1;
      if (cfg[5:4] == 2'h1) return logic'(i < enc);
      return logic'(i % 80 < 64);
   endfunction

   task automatic conclude;
      $display("checks %0d errors %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // One classic cycle; read data taken at the ack edge only
   task automatic wb(input logic [7:0] adr, input logic we, input logic [31:0] dat,
                     output logic [31:0] rd);
      int t;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      wb_sel_i <= 4'hf;
      for (t = 0; t < 50; t++) begin
         @(posedge clk_i);
         if (wb_ack_o === 1'b1) break;
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (t == 50) begin
         n_fail++;
         conclude();
      end
   endtask

   // Every accepted output bit is rebuilt from the partner patterns
   always @(posedge clk_i) begin
      if (!rst_i && dout_valid_o === 1'b1 && dout_ready_i === 1'b1) begin
         `CHK(dout_applied_o, app_exp(m))
         `CHK(dout_bit_o, partner_inst.data_bit(m) ^ (app_exp(m) & partner_inst.key_bit(m)))
         `CHK(dout_last_o, logic'(m == len - 1))
         m++;
      end
   end

   initial begin
      logic [31:0] rd;
      int b, t, s, md;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(mapper_pkg::REG_CFG, 1'b0, 32'h0, rd);
      `CHK(rd, 32'h0)
      wb(mapper_pkg::REG_STATUS, 1'b0, 32'h0, rd);
      `CHK(rd, 32'h0)
      wb(8'h0c, 1'b0, 32'h0, rd);
      `CHK(rd, 32'h0)
      // Half slot cannot take the single-subfield layout
      wb(mapper_pkg::REG_CFG, 1'b1, 32'h10, rd);
      wb(mapper_pkg::REG_CFG, 1'b0, 32'h0, rd);
      `CHK(rd, 32'h10)
      wb(mapper_pkg::REG_CTRL, 1'b1, 32'h1, rd);
      wb(mapper_pkg::REG_STATUS, 1'b0, 32'h0, rd);
      `CHK(rd[2:0], 3'h4)
      wb(mapper_pkg::REG_STATUS, 1'b1, 32'h4, rd);
      wb(mapper_pkg::REG_STATUS, 1'b0, 32'h0, rd);
      `CHK(rd[2:0], 3'h0)
      for (b = 0; b < 12; b++) begin
         cfg = runs[b];
         s = cfg[1:0];
         md = cfg[3:2];
         len = 40 + (s == 0 ? half_b[md] + half_m[md] * cfg[13:8] : s == 1 ? full_u[md] : dbl_u[md]);
         enc = (s == 1) ? full_s[md] : dbl_s[md];
         slow <= b[0];
         hold <= (b == 0);
         restart <= 1'b1;
         @(posedge clk_i);
         restart <= 1'b0;
         m = 0;
         wb(mapper_pkg::REG_CFG, 1'b1, {16'h0, cfg}, rd);
         wb(mapper_pkg::REG_CTRL, 1'b1, 32'h1, rd);
         // First burst: sink stalled until the buffer refuses more
         if (b == 0) begin
            repeat (40) @(posedge clk_i);
            `CHK(dout_valid_o, 1'b1)
            `CHK(ks_ready_o, 1'b0)
            `CHK(din_ready_o, 1'b0)
            hold <= 1'b0;
         end
         for (t = 0; t < 20000 && m < len; t++) @(posedge clk_i);
         if (m < len) begin
            n_fail++;
            conclude();
         end
         wb(mapper_pkg::REG_STATUS, 1'b0, 32'h0, rd);
         `CHK(rd[1:0], 2'h2)
         `CHK(rd[27:16], len[11:0])
         wb(mapper_pkg::REG_STATUS, 1'b1, 32'h2, rd);
      end
      conclude();
   end
endmodule // keystream_bfield_xor_mapper_tb_top

// *** testbench/keystream_partner.sv ***
// Partner model: key stream source, burst bit source and mapped bit sink.
// Assumes the mapper takes one key bit and one burst bit together per handshake.
module keystream_partner (
   // Clock and control
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic restart_i,
   input wire logic slow_i,
   input wire logic hold_i,
   // Source side
   input wire logic take_i,
   output logic ks_valid_o = 1'b0,
   output logic ks_bit_o = 1'b0,
   output logic din_valid_o = 1'b0,
   output logic din_bit_o = 1'b0,
   // Sink side
   output logic dout_ready_o = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   int k = 0;
   int n_cyc = 0;
   int kn;
   logic offer;
   // Fixed patterns so the bench can rebuild every bit
   function automatic logic key_bit(int n);
      return n[0] ^ n[3] ^ n[6] ^ n[9];
   endfunction
   function automatic logic data_bit(int n);
      return n[1] ^ n[2] ^ n[5] ^ n[10];
   endfunction
   // Slow mode leaves a gap every fourth cycle
   assign offer = !(slow_i && (n_cyc % 4 == 0));
   assign kn = k + (take_i ? 1 : 0);
   // bits go out in burst order and hold until taken; idle lines show the inverse
   always @(posedge clk_i) begin
      if (rst_i || restart_i) begin
         k <= 0;
         n_cyc <= 0;
         ks_valid_o <= 1'b0;
         din_valid_o <= 1'b0;
      end else begin
         n_cyc <= n_cyc + 1;
         if (take_i || !ks_valid_o) begin
            k <= kn;
            ks_valid_o <= offer;
            din_valid_o <= offer;
            ks_bit_o <= offer ? key_bit(kn) : ~ks_bit_o;
            din_bit_o <= offer ? data_bit(kn) : ~din_bit_o;
         end
      end
   end
   // Sink stalls on request, or every third cycle when slow
   always @(posedge clk_i) begin
      dout_ready_o <= !rst_i && !hold_i && !(slow_i && (n_cyc % 3 == 0));
   end
endmodule // keystream_partner
